// File: core/dbg_read_pkg.sv
// Package for the cache and translation-buffer debug read block.
// Assumes a single clock domain and a 64-bit general register operand.
package dbg_read_pkg;

    // ****************************************************************
    // System instruction encoding
    // ****************************************************************
    localparam logic [1:0] OP0_DBG  = 2'h1;
    localparam logic [2:0] OP1_DBG  = 3'h6;
    localparam logic [3:0] CRN_DBG  = 4'hf;
    localparam logic [3:0] CRM_GRP3 = 4'h3;
    localparam logic [3:0] CRM_GRP4 = 4'h4;
    localparam logic [3:0] CRM_GRP2 = 4'h2;
    localparam logic [2:0] OP2_0    = 3'h0;
    localparam logic [2:0] OP2_1    = 3'h1;
    localparam logic [2:0] OP2_2    = 3'h2;
    localparam logic [2:0] OP2_3    = 3'h3;

    // ****************************************************************
    // Argument field positions
    // ****************************************************************
    localparam int L1_WAY_LSB  = 30;
    localparam int L1_SET_LSB  = 6;
    localparam int L1_SET_W    = 8;
    localparam int L2_WAY_LSB  = 29;
    localparam int L2_SET_W    = 10;
    localparam int TLB_SET_LSB = 0;
    localparam int DOFF_LSB    = 3;
    localparam int IOFF_LSB    = 2;

    // ****************************************************************
    // Widths, reset value, trap class
    // ****************************************************************
    localparam int TAG_W    = 16;
    localparam int IDATA_W  = 40;
    localparam int TLB_W    = 192;
    localparam logic [63:0] RESULT_RST = 64'h0;
    localparam logic [5:0]  EC_SYS_TRAP = 6'h18;

    // Translation-buffer set split points
    localparam logic [9:0] TLB_MAIN_TOP_1 = 10'h07f;
    localparam logic [9:0] TLB_WALK_TOP_1 = 10'h0a4;
    localparam logic [9:0] TLB_MAIN_TOP_2 = 10'h0ff;
    localparam logic [9:0] TLB_WALK_TOP_2 = 10'h147;

    typedef enum logic [1:0] {
        unprivileged_level,
        kernel_level,
        hypervisor_level,
        monitor_level
    } level_e;

    typedef enum {
        st_idle,
        st_read,
        st_done
    } state_e;

    typedef enum logic [2:0] {
        op_l1_tag, op_l2_tag, op_l1_data, op_l1_instr,
        op_tlb_mid, op_tlb_high, op_l2_data, op_tlb_low
    } op_e;

    // Instruction request
    typedef struct packed {
        logic        valid;
        logic [1:0]  op0;
        logic [2:0]  op1;
        logic [3:0]  crn;
        logic [3:0]  crm;
        logic [2:0]  op2;
        logic [63:0] arg;
    } sys_req_s;

    // Array read request
    typedef struct packed {
        logic        en;
        logic [2:0]  way;
        logic [9:0]  set;
        logic [3:0]  offset;
    } arr_req_s;

endpackage

// File: core/dbg_op_decode.sv
// Decoder for the debug read system instructions.
// Assumes the request fields come straight from the issue stage.
`timescale 1ns/100ps
module dbg_op_decode
    import dbg_read_pkg::*;
(
    // Request
    input  wire sys_req_s req,
    // Decode result
    output op_e           op,
    output logic          hit
);

    // ****************************************************************
    // Encoding match
    // ****************************************************************
    logic family;

    // Common prefix of the family
    assign family = req.op0 == OP0_DBG && req.op1 == OP1_DBG
                    && req.crn == CRN_DBG;

    // Group and op2 select; all ops exist in every build
    always_comb begin
        op  = op_l1_tag;
        hit = 1'b0;
        if (family && req.crm == CRM_GRP3) begin
            hit = 1'b1;
            case (req.op2)
                OP2_0:   op = op_l1_tag;
                OP2_2:   op = op_tlb_mid;
                OP2_3:   op = op_l2_tag;
                default: hit = 1'b0;
            endcase
        end else if (family && req.crm == CRM_GRP4) begin
            hit = 1'b1;
            case (req.op2)
                OP2_0:   op = op_l1_data;
                OP2_1:   op = op_l1_instr;
                OP2_2:   op = op_tlb_high;
                OP2_3:   op = op_l2_data;
                default: hit = 1'b0;
            endcase
        end else if (family && req.crm == CRM_GRP2
                     && req.op2 == OP2_2) begin
            // Low slice of the translation-buffer entry
            hit = 1'b1;
            op  = op_tlb_low;
        end
    end

endmodule // dbg_op_decode

// File: core/dbg_arg_map.sv
// Argument field decode and range folding per target array.
// Assumes set and way limits are given as parameters.
`timescale 1ns/100ps
module dbg_arg_map
    import dbg_read_pkg::*;
#(
    parameter int L1_WAYS  = 4,
    parameter int L1_SETS  = 256,
    parameter int L2_WAYS  = 8,
    parameter int L2_SETS  = 1024,
    parameter int TLB_WAYS = 8,
    parameter bit DUAL     = 1'b0
) (
    // Operation and operand
    input  op_e          op,
    input  wire [63:0]   arg,
    // Array address
    output logic [2:0]   way,
    output logic [9:0]   set,
    output logic [3:0]   offset,
    output logic         walk_sel
);

    logic [9:0] tlb_top;
    logic [9:0] main_top;

    // Split point of main and walk entries
    assign main_top = DUAL ? TLB_MAIN_TOP_2 : TLB_MAIN_TOP_1;
    assign tlb_top  = DUAL ? TLB_WALK_TOP_2 : TLB_WALK_TOP_1;

    // Field extraction and folding of out-of-range values
    always_comb begin
        way      = 3'h0;
        set      = 10'h0;
        offset   = 4'h0;
        walk_sel = 1'b0;
        case (op)
            op_l1_tag, op_l1_data, op_l1_instr: begin
                way = {1'b0, arg[L1_WAY_LSB +: 2]};
                set = {2'h0, arg[L1_SET_LSB +: L1_SET_W]};
                if (op == op_l1_data)
                    offset = {1'b0, arg[DOFF_LSB +: 3]};
                if (op == op_l1_instr)
                    offset = arg[IOFF_LSB +: 4];
                if (32'(way) >= L1_WAYS) way = 3'h0;
                if (32'(set) >= L1_SETS) set = 10'h0;
            end
            op_l2_tag, op_l2_data: begin
                way = arg[L2_WAY_LSB +: 3];
                set = arg[L1_SET_LSB +: L2_SET_W];
                if (op == op_l2_data)
                    offset = {1'b0, arg[DOFF_LSB +: 3]};
                if (32'(way) >= L2_WAYS) way = 3'h0;
                if (32'(set) >= L2_SETS) set = 10'h0;
            end
            default: begin
                way = arg[L2_WAY_LSB +: 3];
                set = arg[TLB_SET_LSB +: 10];
                if (32'(way) >= TLB_WAYS) way = 3'h0;
                if (set > tlb_top) set = 10'h0;
                walk_sel = set > main_top;
            end
        endcase
    end

endmodule // dbg_arg_map

// File: core/cache_tlb_debug_read.sv
// Top of the cache and translation-buffer debug read block.
// Assumes the arrays answer a read one cycle after their enable.
`timescale 1ns/100ps

// Function
// - L1 tag-memory op returns 16 tag bits
// - Mid TLB op returns entry bits 127:64
// - High TLB op returns entry bits 191:128
// - L2 tag-memory op returns 16 tag bits
// - L1 data read returns 64 bits
// - L1 instr read: 40 bits, offset 5:2
// - L2 data read returns 64 bits
// - L1 args: way 31:30, set 13:6, offset 5:3
// - L2 args: way 31:29, set 15:6
// - TLB args: way 31:29, set 9:0
// - Dual-core build uses larger main set range
// - Out-of-range cache address reads some line
// - Out-of-range TLB address reads some entry
// - Unprivileged level: undefined instruction
// - Kernel: trap class 0x18 if enabled, else undefined
// - Hypervisor level: undefined instruction
// - Only monitor level executes with operand
// - Family decoded from op0, op1, CRn
// - CRm and op2 select the operation
// - All ops present in every build
// - Low TLB slice is bits 63:0
module cache_tlb_debug_read
    import dbg_read_pkg::*;
#(
    parameter int L1_WAYS  = 4,
    parameter int L1_SETS  = 256,
    parameter int L2_WAYS  = 8,
    parameter int L2_SETS  = 1024,
    parameter int TLB_WAYS = 8,
    parameter bit DUAL     = 1'b0
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Instruction issue
    input  wire sys_req_s   req,
    input  wire level_e     current_privilege_level,
    input  wire logic       el2_enabled,
    input  wire logic       impdef_trap_control,
    // Array read port
    output arr_req_s        l1d_rd,
    output arr_req_s        l1i_rd,
    output arr_req_s        l2_rd,
    output arr_req_s        tlb_rd,
    output logic            tag_sel,
    output logic            walk_sel,
    input  wire logic [63:0]  l1d_q,
    input  wire logic [39:0]  l1i_q,
    input  wire logic [63:0]  l2_q,
    input  wire logic [191:0] tlb_q,
    input  wire logic [15:0]  l1_tag_q,
    input  wire logic [15:0]  l2_tag_q,
    // Outcome
    output logic            busy,
    output logic            done,
    output logic            undef,
    output logic            trap,
    output logic [5:0]      trap_class,
    output logic [63:0]     debug_read_result
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        state_e      st;
        op_e         op;
        arr_req_s    l1d;
        arr_req_s    l1i;
        arr_req_s    l2;
        arr_req_s    tlb;
        logic        tag;
        logic        walk;
        logic        busy;
        logic        done;
        logic        undef;
        logic        trap;
        logic [5:0]  cls;
        logic [63:0] result;
    } state_s;

    state_s s_r;
    state_s s_nxt;

    op_e        dec_op;
    logic       dec_hit;
    logic [2:0] m_way;
    logic [9:0] m_set;
    logic [3:0] m_off;
    logic       m_walk;
    arr_req_s   a_req;

    // ****************************************************************
    // Decode and argument map
    // ****************************************************************
    dbg_op_decode u_dec (
        .req (req),
        .op  (dec_op),
        .hit (dec_hit)
    );

    dbg_arg_map #(
        .L1_WAYS  (L1_WAYS),
        .L1_SETS  (L1_SETS),
        .L2_WAYS  (L2_WAYS),
        .L2_SETS  (L2_SETS),
        .TLB_WAYS (TLB_WAYS),
        .DUAL     (DUAL)
    ) u_map (
        .op       (dec_op),
        .arg      (req.arg),
        .way      (m_way),
        .set      (m_set),
        .offset   (m_off),
        .walk_sel (m_walk)
    );

    assign a_req = '{en: 1'b1, way: m_way, set: m_set, offset: m_off};

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_nxt       = s_r;
        s_nxt.done  = 1'b0;
        s_nxt.undef = 1'b0;
        s_nxt.trap  = 1'b0;
        s_nxt.l1d.en = 1'b0;
        s_nxt.l1i.en = 1'b0;
        s_nxt.l2.en  = 1'b0;
        s_nxt.tlb.en = 1'b0;
        case (s_r.st)
            st_idle: begin
                if (req.valid && dec_hit) begin
                    case (current_privilege_level)
                        monitor_level: begin
                            s_nxt.st   = st_read;
                            s_nxt.busy = 1'b1;
                            s_nxt.op   = dec_op;
                            s_nxt.walk = m_walk;
                            s_nxt.tag  = dec_op == op_l1_tag
                                         || dec_op == op_l2_tag;
                            case (dec_op)
                                op_l1_tag, op_l1_data: s_nxt.l1d = a_req;
                                op_l1_instr:           s_nxt.l1i = a_req;
                                op_l2_tag, op_l2_data: s_nxt.l2  = a_req;
                                default:               s_nxt.tlb = a_req;
                            endcase
                        end
                        kernel_level: begin
                            if (el2_enabled && impdef_trap_control) begin
                                s_nxt.trap = 1'b1;
                                s_nxt.cls  = EC_SYS_TRAP;
                            end else begin
                                s_nxt.undef = 1'b1;
                            end
                        end
                        default: s_nxt.undef = 1'b1;
                    endcase
                end
            end
            st_read: begin
                s_nxt.st = st_done;
            end
            st_done: begin
                // Capture array data, zero-extend narrow items
                case (s_r.op)
                    op_l1_tag:   s_nxt.result = 64'(l1_tag_q);
                    op_l2_tag:   s_nxt.result = 64'(l2_tag_q);
                    op_l1_data:  s_nxt.result = l1d_q;
                    op_l1_instr: s_nxt.result = 64'(l1i_q);
                    op_l2_data:  s_nxt.result = l2_q;
                    op_tlb_mid:  s_nxt.result = tlb_q[127:64];
                    op_tlb_high: s_nxt.result = tlb_q[191:128];
                    op_tlb_low:  s_nxt.result = tlb_q[63:0];
                    default:     s_nxt.result = s_r.result;
                endcase
                s_nxt.st   = st_idle;
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
                s_nxt.tag  = 1'b0;
                s_nxt.walk = 1'b0;
            end
            default: s_nxt.st = st_idle;
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r        <= '0;
            s_r.st     <= st_idle;
            s_r.op     <= op_l1_tag;
            s_r.result <= RESULT_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign l1d_rd            = s_r.l1d;
    assign l1i_rd            = s_r.l1i;
    assign l2_rd             = s_r.l2;
    assign tlb_rd            = s_r.tlb;
    assign tag_sel           = s_r.tag;
    assign walk_sel          = s_r.walk;
    assign busy              = s_r.busy;
    assign done              = s_r.done;
    assign undef             = s_r.undef;
    assign trap              = s_r.trap;
    assign trap_class        = s_r.cls;
    assign debug_read_result = s_r.result;

endmodule // cache_tlb_debug_read

// File: tb/dbg_read_sva.sv
// Checker for the cache and translation-buffer debug read block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module dbg_read_sva
    import dbg_read_pkg::*;
#(
    parameter bit DUAL = 1'b0
) (
    // Clock, reset and issue
    input wire logic   clk,
    input wire logic   rst,
    input wire sys_req_s req,
    input wire level_e current_privilege_level,
    input wire logic   el2_enabled,
    input wire logic   impdef_trap_control,
    // Array reads and outcome
    input wire arr_req_s l1d_rd,
    input wire arr_req_s l1i_rd,
    input wire arr_req_s tlb_rd,
    input wire logic   tag_sel,
    input wire logic   busy,
    input wire logic   done,
    input wire logic   undef,
    input wire logic   trap,
    input wire logic [5:0]  trap_class,
    input wire logic [63:0] debug_read_result
);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    logic [63:0] arg_r;
    logic [9:0]  top;
    logic        fam, take, mon, kt;
    // Family decode and accepted request
    assign fam = req.op0 == OP0_DBG && req.op1 == OP1_DBG
        && req.crn == CRN_DBG && !req.op2[2]
        && (req.crm == CRM_GRP4
            || (req.crm == CRM_GRP3 && req.op2 != OP2_1)
            || (req.crm == CRM_GRP2 && req.op2 == OP2_2));
    assign take = req.valid && fam && !busy && !done;
    assign mon = current_privilege_level == monitor_level;
    assign kt = current_privilege_level == kernel_level
        && el2_enabled && impdef_trap_control;
    assign top = DUAL ? TLB_WALK_TOP_2 : TLB_WALK_TOP_1;
    // Operand of the request taken last edge
    always_ff @(posedge clk) begin
        arg_r <= req.arg;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ****************************************************************
    // Assertions
    // ****************************************************************
    undef_low_a: assert property (take && current_privilege_level ==
        unprivileged_level |=> undef && !trap)
        else $error("undef missing at lowest level");
    trap_kern_a: assert property (take && kt |=> trap && !undef
        && trap_class == EC_SYS_TRAP) else $error("trap missing");
    undef_kern_a: assert property (take && !kt &&
        current_privilege_level == kernel_level |=> undef && !trap)
        else $error("undef missing at kernel level");
    undef_hyp_a: assert property (take && current_privilege_level ==
        hypervisor_level |=> undef && !trap)
        else $error("undef missing at hypervisor level");
    read_seq_a: assert property (take && mon |=> busy && !done
        ##1 busy ##1 done && !busy) else $error("read sequence wrong");
    fault_keep_a: assert property (take && !mon |=>
        $stable(debug_read_result) && !busy && !l1d_rd.en && !tlb_rd.en)
        else $error("fault changed state");
    l1_arg_a: assert property (take && mon && req.crm == CRM_GRP4
        && req.op2 == OP2_0 |=> l1d_rd.en
        && l1d_rd.way == {1'b0, arg_r[31:30]}
        && l1d_rd.set == {2'b0, arg_r[13:6]}
        && l1d_rd.offset == {1'b0, arg_r[5:3]})
        else $error("l1 data address wrong");
    ioff_a: assert property (take && mon && req.crm == CRM_GRP4
        && req.op2 == OP2_1 |=> l1i_rd.en
        && l1i_rd.offset == arg_r[5:2]) else $error("offset wrong");
    tlb_arg_a: assert property (take && mon && req.op2 == OP2_2
        |=> tlb_rd.en && tlb_rd.way == arg_r[31:29] && tlb_rd.set ==
        (arg_r[9:0] > top ? 10'h0 : arg_r[9:0]))
        else $error("tlb address wrong");
    tag_zero_a: assert property (done && $past(tag_sel) |->
        debug_read_result[63:16] == 48'h0) else $error("tag not zeroed");
    // Main scenarios reached
    cover property (done);
    cover property (trap);
    cover property (undef);
endmodule // dbg_read_sva

bind cache_tlb_debug_read dbg_read_sva #(.DUAL(DUAL)) i_dbg_read_sva (
    .clk, .rst, .req, .current_privilege_level, .el2_enabled,
    .impdef_trap_control, .l1d_rd, .l1i_rd, .tlb_rd, .tag_sel, .busy,
    .done, .undef, .trap, .trap_class, .debug_read_result);

// File: tb/cache_tlb_debug_read_bench.sv
// Self-checking bench for the debug read block.
// Assumes the bench drives the arrays and holds them per request.
`timescale 1ns/100ps
module cache_tlb_debug_read_bench
    import dbg_read_pkg::*;
;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        clk, rst, el2_enabled, impdef_trap_control;
    logic        busy, done, undef, trap, tag_sel, walk_sel;
    arr_req_s    l1d_rd, l1i_rd, l2_rd, tlb_rd;
    sys_req_s    req;
    level_e      current_privilege_level;
    logic [63:0] l1d_q, l2_q, debug_read_result, res;
    logic [39:0] l1i_q;
    logic [191:0] tlb_q;
    logic [15:0] l1_tag_q, l2_tag_q;
    logic [5:0]  trap_class;
    logic [31:0] seed = 32'h5edb;
    logic [3:0]  crm_t [9] = '{4'h3, 4'h3, 4'h3, 4'h4, 4'h4, 4'h4, 4'h4,
                               4'h2, 4'h2};
    logic [2:0]  op2_t [9] = '{3'h0, 3'h2, 3'h3, 3'h0, 3'h1, 3'h2, 3'h3,
                               3'h2, 3'h0};
    int          num_errors, num_checks;

    cache_tlb_debug_read i_cache_tlb_debug_read (
        .clk, .rst, .req, .current_privilege_level, .el2_enabled,
        .impdef_trap_control, .l1d_rd, .l1i_rd, .l2_rd, .tlb_rd,
        .tag_sel, .walk_sel, .l1d_q, .l1i_q, .l2_q, .tlb_q, .l1_tag_q,
        .l2_tag_q, .busy, .done, .undef, .trap, .trap_class,
        .debug_read_result);

    // Clock of 20 ns
    always #10 clk = ~clk;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One request, k 8 is in the family but decodes to no operation
    task automatic run(input int k, input logic [1:0] lv, input logic e2,
                       input logic tc);
        logic [191:0] t;
        logic [63:0]  u, w, e, a;
        logic [17:0]  ea, ga;
        logic [9:0]   ts;
        logic [1:0]   es;
        logic         tr;
        int           n;
        t = {xs(), xs(), xs(), xs(), xs(), xs()};
        u = {xs(), xs()};
        w = {xs(), xs()};
        a = {xs(), xs()};
        tr = lv == 2'h1 && e2 && tc;
        // Expected array address, TLB set beyond the top folded to 0
        ts = a[9:0] > TLB_WALK_TOP_1 ? 10'h0 : a[9:0];
        case (k)
            0, 3, 4: ea = {2'h2, a[31:30], 2'h0, a[13:6], 4'h0};
            2, 6:    ea = {1'b1, a[31:29], a[15:6], 4'h0};
            default: ea = {1'b1, a[31:29], ts, 4'h0};
        endcase
        if (k == 3 || k == 6) ea[3:0] = {1'b0, a[5:3]};
        if (k == 4) ea[3:0] = a[5:2];
        es = {k == 0 || k == 2,
              (k == 1 || k == 5 || k == 7) && ts > TLB_MAIN_TOP_1};
        case (k)
            0: e = 64'(w[15:0]);
            1: e = t[127:64];
            2: e = 64'(u[15:0]);
            3: e = u;
            4: e = 64'(w[63:24]);
            5: e = t[191:128];
            6: e = w;
            7: e = t[63:0];
            default: e = res;
        endcase
        @(posedge clk);
        req <= '{1'b1, OP0_DBG, OP1_DBG, CRN_DBG, crm_t[k], op2_t[k], a};
        current_privilege_level <= level_e'(lv);
        el2_enabled <= e2;
        impdef_trap_control <= tc;
        tlb_q <= t;
        l1d_q <= u;
        l2_q <= w;
        l1i_q <= w[63:24];
        l1_tag_q <= w[15:0];
        l2_tag_q <= u[15:0];
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        if (k == 8 || lv != 2'h3) begin
            chk(64'({undef, trap}), 64'({k < 8 && !tr, k < 8 && tr}));
            chk(debug_read_result, res);
            if (tr) chk(64'(trap_class), 64'(EC_SYS_TRAP));
            if (k == 8) begin
                repeat (2) @(posedge clk);
                #1;
                chk(64'({busy, done}), 64'h0);
            end
        end else begin
            // Array request seen one cycle after the take
            case (k)
                0, 3:    ga = l1d_rd;
                4:       ga = l1i_rd;
                2, 6:    ga = l2_rd;
                default: ga = tlb_rd;
            endcase
            chk(64'(ga), 64'(ea));
            chk(64'({tag_sel, walk_sel}), 64'(es));
            n = 0;
            while (done !== 1'b1 && n < 8) begin
                @(posedge clk);
                #1;
                n++;
            end
            chk(64'(n), 64'h2);
            chk(debug_read_result, e);
            res = e;
        end
    endtask

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        req = '0;
        current_privilege_level = monitor_level;
        {el2_enabled, impdef_trap_control} = 2'b0;
        {l1d_q, l2_q, l1i_q, tlb_q, l1_tag_q, l2_tag_q} = '0;
        res = 64'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(debug_read_result, res);
        // Every operation at the top level, then refused levels
        for (int k = 0; k < 9; k++) run(k, 2'h3, 1'b0, 1'b0);
        for (int l = 0; l < 3; l++)
            for (int c = 0; c < 4; c++) run(c + l, 2'(l), c[0], c[1]);
        // Random mix, arguments beyond the implemented range too
        repeat (80) run(int'(xs() % 9), 2'(xs()), 1'(xs()), 1'(xs()));
        end_sim();
    end

    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        end_sim();
    end
endmodule // cache_tlb_debug_read_bench
